// ### rtl/swm_pkg.sv
// Constants for the single-wire link master: timing figures and slot kinds.
// Assumes a 40 MHz system clock; all counts derive from CLK_MHZ.
package swm_pkg;

    // ==============================================================
    // Clock
    localparam int CLK_MHZ = 40;

    // ==============================================================
    // Regular speed times, in microseconds
    localparam int RESET_LOW_PULSE_TIME_US       = 480;
    localparam int RESET_LOW_MAX_US              = 960;
    localparam int RESET_HIGH_RECOVERY_TIME_US   = 480;
    localparam int PRESENCE_SAMPLE_US            = 70;
    localparam int WRITE_ONE_LOW_TIME_US         = 1;
    localparam int WRITE_ZERO_LOW_TIME_US        = 60;
    localparam int READ_START_LOW_TIME_US        = 1;
    localparam int READ_VALID_WINDOW_US          = 15;
    localparam int BIT_SLOT_LENGTH_US            = 60;
    localparam int SLOT_RECOVERY_TIME_US         = 1;
    localparam int COPY_WAIT_TIME_US             = 5000;

    // ==============================================================
    // Overdrive speed times, in microseconds
    localparam int OD_RESET_LOW_PULSE_TIME_US     = 48;
    localparam int OD_RESET_HIGH_RECOVERY_TIME_US = 48;
    localparam int OD_PRESENCE_SAMPLE_US          = 8;
    localparam int OD_WRITE_ZERO_LOW_TIME_US      = 6;
    localparam int OD_READ_VALID_WINDOW_US        = 2;
    localparam int OD_BIT_SLOT_LENGTH_US          = 6;

    // ==============================================================
    // Cycle counts (least times; all whole microseconds so exact)
    localparam int CNT_W = 18;
    localparam int RST_LOW_CYC      = RESET_LOW_PULSE_TIME_US * CLK_MHZ;
    localparam int RST_HIGH_CYC     = RESET_HIGH_RECOVERY_TIME_US * CLK_MHZ;
    localparam int PRES_SMP_CYC     = PRESENCE_SAMPLE_US * CLK_MHZ;
    localparam int W1_LOW_CYC       = WRITE_ONE_LOW_TIME_US * CLK_MHZ;
    localparam int W0_LOW_CYC       = WRITE_ZERO_LOW_TIME_US * CLK_MHZ;
    localparam int RD_LOW_CYC       = READ_START_LOW_TIME_US * CLK_MHZ;
    // Sample three cycles before the window closes: synchroniser delay
    localparam int RD_SMP_CYC       = READ_VALID_WINDOW_US * CLK_MHZ - 3;
    localparam int SLOT_CYC         = BIT_SLOT_LENGTH_US * CLK_MHZ;
    localparam int REC_CYC          = SLOT_RECOVERY_TIME_US * CLK_MHZ;
    localparam int COPY_CYC         = COPY_WAIT_TIME_US * CLK_MHZ;
    localparam int OD_RST_LOW_CYC   = OD_RESET_LOW_PULSE_TIME_US * CLK_MHZ;
    localparam int OD_RST_HIGH_CYC  = OD_RESET_HIGH_RECOVERY_TIME_US * CLK_MHZ;
    localparam int OD_PRES_SMP_CYC  = OD_PRESENCE_SAMPLE_US * CLK_MHZ;
    localparam int OD_W0_LOW_CYC    = OD_WRITE_ZERO_LOW_TIME_US * CLK_MHZ;
    localparam int OD_RD_SMP_CYC    = OD_READ_VALID_WINDOW_US * CLK_MHZ - 3;
    localparam int OD_SLOT_CYC      = OD_BIT_SLOT_LENGTH_US * CLK_MHZ;

    // ==============================================================
    // Commands
    typedef enum logic [2:0] {
        SWM_CMD_RESET,
        SWM_CMD_WRITE0,
        SWM_CMD_WRITE1,
        SWM_CMD_READ,
        SWM_CMD_COPY_WAIT
    } swm_cmd_t;

    localparam int CMD_W = 3;

endpackage

// ### rtl/swm_skid.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; a stall on the drain side back-pressures the fill side.
`timescale 1ns/1ps
`default_nettype none
module swm_skid
    import swm_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic             wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0]       cnt_reg, cnt_next;
    logic             out_valid_reg, out_valid_next;
    logic [WIDTH-1:0] out_data_reg, out_data_next;

    // ==============================================================
    // Next state
    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop  = 1'b0;
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        push = in_valid && (cnt_reg != 2'h2);
        pop  = out_ready && (cnt_reg != 2'h0);
        if (push) begin
            mem_next[wp_reg] = in_data;
            wp_next = ~wp_reg;
        end
        if (pop) begin
            rp_next = ~rp_reg;
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        // Drain side registered so the ports come straight from flops
        out_valid_next = (cnt_next != 2'h0);
        out_data_next  = mem_next[rp_next];
    end

    // ==============================================================
    // Registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wp_reg     <= 1'b0;
            rp_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
            out_valid_reg <= out_valid_next;
            out_data_reg  <= out_data_next;
        end
    end

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

endmodule // swm_skid
`default_nettype wire

// ### rtl/swm_master.sv
// Single-wire link master: resets, bit slots and copy wait on an open-drain pin.
// Assumes an external pullup on the wire; the pin is given as in/out/enable.
//
// Overview of operation
// - After each reset the master holds off all activity for the reset-high recovery time.
// - The reset low pulse stays well under the 960 us ceiling.
// - Read bits are sampled late in the read-valid window but never after it closes.
// - Write-one and read low pulses last 1 us, inside the 15 us or 2 us ceiling.
// - Every bit slot begins with the master pulling the wire low.
`timescale 1ns/1ps
`default_nettype none
module swm_master
    import swm_pkg::*;
#(
    parameter int COPY_CYCLES = COPY_CYC
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // Command port
    input  wire logic             cmd_valid,
    output logic                  cmd_ready,
    input  wire logic [CMD_W-1:0] cmd_op,
    input  wire logic             overdrive,
    // Result port
    output logic                  res_valid,
    input  wire logic             res_ready,
    output logic                  res_bit,
    output logic                  res_presence,
    // Wire
    input  wire logic             wire_in,
    output logic                  wire_out,
    output logic                  wire_oe
);

    typedef enum logic [2:0] {
        SWM_IDLE, SWM_RST_LOW, SWM_RST_HIGH, SWM_SLOT, SWM_REC, SWM_COPY
    } swm_state_t;

    swm_state_t       state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] low_reg, low_next;
    logic [CNT_W-1:0] smp_reg, smp_next;
    logic [CNT_W-1:0] end_reg, end_next;
    logic             od_reg, od_next;
    logic             rd_reg, rd_next;
    logic             oe_reg, oe_next;
    logic             push_reg, push_next;
    logic [1:0]       data_reg, data_next;
    logic             cmd_ready_reg, cmd_ready_next;
    logic             sync1_reg, sync2_reg;
    logic             buf_ready, buf_valid;
    logic [1:0]       buf_data;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = n[CNT_W-1:0];
    endfunction

    // ==============================================================
    // Pin synchroniser
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= wire_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ==============================================================
    // Slot sequencer
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + cyc(1);
        low_next   = low_reg;
        smp_next   = smp_reg;
        end_next   = end_reg;
        od_next    = od_reg;
        rd_next    = rd_reg;
        oe_next    = oe_reg;
        push_next  = 1'b0;
        data_next  = data_reg;
        case (state_reg)
            SWM_IDLE: begin
                cnt_next = '0;
                // Buffer full stalls new commands so no result is lost
                if (cmd_valid && cmd_ready_reg) begin
                    od_next = overdrive;
                    rd_next = 1'b0;
                    if (cmd_op == SWM_CMD_RESET) begin
                        // 480 us drops to regular speed; 48 us stays under 80 us
                        low_next   = overdrive ? cyc(OD_RST_LOW_CYC) : cyc(RST_LOW_CYC);
                        smp_next   = overdrive ? cyc(OD_PRES_SMP_CYC) : cyc(PRES_SMP_CYC);
                        end_next   = overdrive ? cyc(OD_RST_HIGH_CYC) : cyc(RST_HIGH_CYC);
                        oe_next    = 1'b1;
                        state_next = SWM_RST_LOW;
                    end else if (cmd_op == SWM_CMD_COPY_WAIT) begin
                        oe_next    = 1'b0;
                        state_next = SWM_COPY;
                    end else begin
                        if (cmd_op == SWM_CMD_WRITE0) begin
                            low_next = overdrive ? cyc(OD_W0_LOW_CYC) : cyc(W0_LOW_CYC);
                        end else if (cmd_op == SWM_CMD_WRITE1) begin
                            low_next = cyc(W1_LOW_CYC);
                        end else begin
                            low_next = cyc(RD_LOW_CYC);
                            rd_next  = 1'b1;
                        end
                        smp_next   = overdrive ? cyc(OD_RD_SMP_CYC) : cyc(RD_SMP_CYC);
                        end_next   = overdrive ? cyc(OD_SLOT_CYC) : cyc(SLOT_CYC);
                        oe_next    = 1'b1;
                        state_next = SWM_SLOT;
                    end
                end
            end
            SWM_RST_LOW: begin
                if (cnt_reg == low_reg - cyc(1)) begin
                    oe_next    = 1'b0;
                    cnt_next   = '0;
                    state_next = SWM_RST_HIGH;
                end
            end
            SWM_RST_HIGH: begin
                if (cnt_reg == smp_reg) begin
                    data_next = {~sync2_reg, 1'b0};
                end
                // Nothing new starts before recovery has run out
                if (cnt_reg == end_reg - cyc(1)) begin
                    push_next  = 1'b1;
                    state_next = SWM_IDLE;
                end
            end
            SWM_SLOT: begin
                if (cnt_reg == low_reg - cyc(1)) begin
                    oe_next = 1'b0;
                end
                // Device data valid well before this point, sampled late
                if (rd_reg && cnt_reg == smp_reg) begin
                    data_next = {1'b0, sync2_reg};
                end
                if (cnt_reg == end_reg - cyc(1)) begin
                    cnt_next   = '0;
                    state_next = SWM_REC;
                end
            end
            SWM_REC: begin
                if (cnt_reg == cyc(REC_CYC) - cyc(1)) begin
                    push_next  = rd_reg;
                    state_next = SWM_IDLE;
                end
            end
            SWM_COPY: begin
                // Wire stays released so the pullup powers the write
                if (cnt_reg == COPY_CYCLES[CNT_W-1:0] - cyc(1)) begin
                    state_next = SWM_IDLE;
                end
            end
            default: begin
                state_next = SWM_IDLE;
            end
        endcase
        // Hold off while a result is in flight so the buffer never overflows
        cmd_ready_next = (state_next == SWM_IDLE) && buf_ready && !push_next && !push_reg;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg     <= SWM_IDLE;
            cnt_reg       <= '0;
            low_reg       <= '0;
            smp_reg       <= '0;
            end_reg       <= '0;
            od_reg        <= 1'b0;
            rd_reg        <= 1'b0;
            oe_reg        <= 1'b0;
            push_reg      <= 1'b0;
            data_reg      <= 2'h0;
            cmd_ready_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            low_reg       <= low_next;
            smp_reg       <= smp_next;
            end_reg       <= end_next;
            od_reg        <= od_next;
            rd_reg        <= rd_next;
            oe_reg        <= oe_next;
            push_reg      <= push_next;
            data_reg      <= data_next;
            cmd_ready_reg <= cmd_ready_next;
        end
    end

    // ==============================================================
    // Result buffer
    swm_skid #(
        .WIDTH (2)
    ) u_skid (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (push_reg),
        .in_ready  (buf_ready),
        .in_data   (data_reg),
        .out_valid (buf_valid),
        .out_ready (res_ready),
        .out_data  (buf_data)
    );

    assign cmd_ready    = cmd_ready_reg;
    assign wire_oe      = oe_reg;
    assign wire_out     = 1'b0;
    assign res_valid    = buf_valid;
    assign res_bit      = buf_data[0];
    assign res_presence = buf_data[1];

endmodule // swm_master
`default_nettype wire

// ### bench/swm_master_chk.sv
// Checker for the single-wire master: pulse lengths, gaps and handshakes.
// Assumes it is bound to swm_master and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module swm_master_chk
    import swm_pkg::*;
#(
    parameter int COPY_CYCLES = COPY_CYC
) (
    // Clock and reset
    input wire logic             clk_sys,
    input wire logic             sys_rst,
    // Command and result
    input wire logic             cmd_valid,
    input wire logic             cmd_ready,
    input wire logic [CMD_W-1:0] cmd_op,
    input wire logic             overdrive,
    input wire logic             res_valid,
    input wire logic             res_ready,
    input wire logic             res_bit,
    input wire logic             res_presence,
    // Wire
    input wire logic             wire_in,
    input wire logic             wire_out,
    input wire logic             wire_oe
);
    // ==========
    // Pulse and gap counters; idle count saturates so it never wraps
    logic [31:0] hi_reg, hi_next, lo_reg, lo_next, gap_reg, gap_next;

    always_comb begin
        hi_next  = wire_oe ? hi_reg + 32'h1 : 32'h0;
        lo_next  = wire_oe ? 32'h0 : lo_reg + 32'(lo_reg != '1);
        gap_next = gap_reg;
        if (!wire_oe && hi_reg != 32'h0)
            gap_next = (hi_reg == RST_LOW_CYC) ? RST_HIGH_CYC :
                       (hi_reg == OD_RST_LOW_CYC) ? OD_RST_HIGH_CYC : REC_CYC;
        if (cmd_valid && cmd_ready && cmd_op == CMD_W'(SWM_CMD_COPY_WAIT))
            gap_next = lo_reg + COPY_CYCLES;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hi_reg  <= 32'h0;
            lo_reg  <= '1;
            gap_reg <= 32'h0;
        end else begin
            hi_reg  <= hi_next;
            lo_reg  <= lo_next;
            gap_reg <= gap_next;
        end
    end

    // ==========
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_taken;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_quiet;
        (!wire_oe && !cmd_ready) [*8];
    endsequence

    property p_open_drain;
        wire_oe |-> !wire_out;
    endproperty
    property p_slot_start;
        s_taken ##0 (cmd_op != CMD_W'(SWM_CMD_COPY_WAIT)) |-> ##[1:2] wire_oe;
    endproperty
    property p_cmd_busy;
        s_taken |=> !cmd_ready;
    endproperty
    property p_pulse_len;
        $fell(wire_oe) |->
            hi_reg inside {W1_LOW_CYC, W0_LOW_CYC, OD_W0_LOW_CYC, RST_LOW_CYC, OD_RST_LOW_CYC};
    endproperty
    property p_reset_max;
        wire_oe |-> hi_reg < RESET_LOW_MAX_US * CLK_MHZ;
    endproperty
    property p_gap;
        $rose(wire_oe) |-> lo_reg >= gap_reg;
    endproperty
    property p_copy_quiet;
        s_taken ##0 (cmd_op == CMD_W'(SWM_CMD_COPY_WAIT)) |=> s_quiet;
    endproperty
    property p_res_hold;
        res_valid && !res_ready |=> res_valid && $stable(res_bit) && $stable(res_presence);
    endproperty

    a_open_drain: assert property (p_open_drain)
        else $error("wire driven high");
    a_slot_start: assert property (p_slot_start)
        else $error("no low pulse after command");
    a_cmd_busy: assert property (p_cmd_busy)
        else $error("ready while busy");
    a_pulse_len: assert property (p_pulse_len)
        else $error("low pulse length wrong");
    a_reset_max: assert property (p_reset_max)
        else $error("reset low too long");
    a_gap: assert property (p_gap)
        else $error("gap before low pulse too short");
    a_copy_quiet: assert property (p_copy_quiet)
        else $error("activity during copy wait");
    a_res_hold: assert property (p_res_hold)
        else $error("result changed while stalled");
endmodule // swm_master_chk

bind swm_master swm_master_chk #(.COPY_CYCLES(COPY_CYCLES)) u_swm_master_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .overdrive(overdrive), .res_valid(res_valid), .res_ready(res_ready),
    .res_bit(res_bit), .res_presence(res_presence), .wire_in(wire_in),
    .wire_out(wire_out), .wire_oe(wire_oe));
`default_nettype wire

// ### bench/swm_dev_model.sv
// Behavioural model of the memory device on the single wire.
// Assumes the wire level is formed outside from all pull-downs and a pullup.
// Copy with its built-in erase ends at once here
`timescale 1ns/1ps
`default_nettype none
module swm_dev_model (
    // Wire
    input  wire logic line,
    output logic      pull_low,
    // Behaviour selects
    input  wire logic present,
    input  wire logic slow,
    input  wire logic od_en,
    input  wire logic tx_zero
);
    realtime t_fall;
    realtime low_len;
    logic    od;

    initial begin
        pull_low = 1'b0;
        od = 1'b0;
        t_fall = 0;
    end

    always @(posedge od_en) od = 1'b1;

    // Falling edge starts the slot delay
    always @(negedge line) begin
        t_fall = $realtime;
        if (tx_zero && !pull_low) begin
            #500 pull_low = 1'b1;
            #((od ? 2000 : 15000) - 500) pull_low = 1'b0;
        end
    end

    // Long reset forces regular speed; presence follows release
    always @(posedge line) begin
        low_len = $realtime - t_fall;
        if (low_len >= 480000) od = 1'b0;
        if (present && low_len >= (od ? 48000 : 480000)) begin
            #(slow ? (od ? 6000 : 60000) : (od ? 2000 : 15000)) pull_low = 1'b1;
            #(od ? 16000 : 120000) pull_low = 1'b0;
        end
    end
endmodule // swm_dev_model
`default_nettype wire

// ### bench/swm_master_test.sv
// Testbench for the single-wire master against the device model.
// Assumes a pullup on the wire; copy wait is cut to COPY_T cycles.
`timescale 1ns/1ps
`default_nettype none
module swm_master_test
    import swm_pkg::*;
;
    localparam int COPY_T = 100;
    localparam int LIMIT  = 120000;
    logic       clk_sys = 1'b0;
    logic       sys_rst, cmd_valid, cmd_ready, overdrive, res_valid, res_ready;
    logic       res_bit, res_presence, wire_out, wire_oe, pull_low;
    logic       present, slow, od_en, tx_zero;
    logic [2:0] cmd_op;
    wire        line = ~(wire_oe & ~wire_out) & ~pull_low;
    int         num_errors = 0, total_checks = 0, cyc = 0;
    int         oe_len = 0, last_len = 0, low_run = 0;

    always #12.5 clk_sys = ~clk_sys;

    swm_master #(.COPY_CYCLES(COPY_T)) u_swm_master (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .overdrive(overdrive), .res_valid(res_valid), .res_ready(res_ready),
        .res_bit(res_bit), .res_presence(res_presence), .wire_in(line),
        .wire_out(wire_out), .wire_oe(wire_oe));
    swm_dev_model u_swm_dev_model (.line(line), .pull_low(pull_low), .present(present),
        .slow(slow), .od_en(od_en), .tx_zero(tx_zero));

    // ==========
    // Pulse monitor and watchdog
    always @(posedge clk_sys) begin
        oe_len  <= (wire_oe === 1'b1) ? oe_len + 1 : 0;
        low_run <= (wire_oe === 1'b1) ? 0 : low_run + 1;
        if (wire_oe !== 1'b1 && oe_len != 0) last_len <= oe_len;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            conclude();
        end
    end

    // ==========
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 10000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 10000)
            num_errors++;
    endtask

    task automatic issue(input swm_cmd_t op, input logic od);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        overdrive <= od;
        wait_ready();
        cmd_valid <= 1'b0;
    endtask

    task automatic take_res(output logic b, output logic p);
        int n;
        n = 0;
        @(posedge clk_sys);
        res_ready <= 1'b1;
        @(posedge clk_sys);
        while (res_valid !== 1'b1 && n < 50000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 50000)
            num_errors++;
        b = res_bit;
        p = res_presence;
        res_ready <= 1'b0;
    endtask

    task automatic conclude();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========
    // Scenarios
    task automatic t_reset(input logic od, input logic exp_p);
        logic b, p;
        issue(SWM_CMD_RESET, od);
        take_res(b, p);
        check(low_run >= (od ? OD_RST_HIGH_CYC : RST_HIGH_CYC), 1);
        check(p, exp_p);
        check(last_len, od ? OD_RST_LOW_CYC : RST_LOW_CYC);
    endtask

    task automatic t_read(input logic od, input logic bitv);
        logic b, p;
        tx_zero <= !bitv;
        issue(SWM_CMD_READ, od);
        take_res(b, p);
        tx_zero <= 1'b0;
        check(b, bitv);
        check(last_len, RD_LOW_CYC);
    endtask

    task automatic t_write(input swm_cmd_t op, input logic od, input int exp_len);
        issue(op, od);
        wait_ready();
        check(last_len, exp_len);
        check(res_valid, 0);
    endtask

    task automatic t_copy();
        int n;
        n = 0;
        issue(SWM_CMD_COPY_WAIT, 1'b0);
        @(posedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 1000) begin
            check(wire_oe, 0);
            @(posedge clk_sys);
            n++;
        end
        check(n, COPY_T);
    endtask

    // Receiver stalls: two results held, further commands refused
    task automatic t_buffer();
        logic b, p;
        tx_zero <= 1'b1;
        issue(SWM_CMD_READ, 1'b1);
        issue(SWM_CMD_READ, 1'b1);
        tx_zero <= 1'b0;
        repeat (400) @(posedge clk_sys);
        check(cmd_ready, 0);
        take_res(b, p);
        check(b, 0);
        take_res(b, p);
        check(b, 1);
    endtask

    initial begin
        cmd_valid = 1'b0;
        cmd_op = SWM_CMD_RESET;
        overdrive = 1'b0;
        res_ready = 1'b0;
        present = 1'b1;
        slow = 1'b0;
        od_en = 1'b0;
        tx_zero = 1'b0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_reset(1'b0, 1'b1);
        t_read(1'b0, 1'b0);
        t_read(1'b0, 1'b1);
        t_write(SWM_CMD_WRITE0, 1'b0, W0_LOW_CYC);
        t_write(SWM_CMD_WRITE1, 1'b0, W1_LOW_CYC);
        t_copy();
        od_en <= 1'b1;
        slow <= 1'b1;
        t_reset(1'b1, 1'b1);
        t_write(SWM_CMD_WRITE0, 1'b1, OD_W0_LOW_CYC);
        t_buffer();
        present <= 1'b0;
        t_reset(1'b1, 1'b0);
        present <= 1'b1;
        t_reset(1'b0, 1'b1);
        conclude();
    end
endmodule // swm_master_test
`default_nettype wire
